/* File: inc/pic_defines.svh */
// Offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

`define PIC_NSRC         10
`define PIC_ADDR_CLEAR0  8'hDA
`define PIC_ADDR_CLEAR1  8'hDB
`define PIC_ADDR_MASK0   8'hE0
`define PIC_ADDR_MASK1   8'hE1
`define PIC_ADDR_SWPOST  8'hE2
`define PIC_ADDR_FLAGS   8'hF0
`define PIC_FLAG_GIE     0
`define PIC_SWPOST_EN    0
`define PIC_RST_BYTE     8'h00
`define PIC_CLEAR1_BITS  2
`define PIC_ENTRY_CYCLES 4'hD
`define PIC_PUSH_CYCLES  4'h3
`define PIC_RET_LAST     4'h4
`define PIC_VEC_STEP     4

`endif

/* File: inc/pic_pkg.sv */
// Types of the interrupt controller
`include "pic_defines.svh"

package pic_pkg;

    typedef enum logic [1:0] {
        PIC_IDLE,
        PIC_ENTRY,
        PIC_RET
    } pic_state_t;

    typedef struct packed {
        pic_state_t            state;
        logic [3:0]            cnt;
        logic [`PIC_NSRC-1:0]  posted;
        logic [`PIC_NSRC-1:0]  mask;
        logic                  swpost;
        logic [7:0]            flags;
        logic [7:0]            flags_tmp;
        logic [15:0]           pc_save;
        logic [7:0]            rdata;
        logic                  busy;
        logic                  push;
        logic [7:0]            push_data;
        logic                  pop;
        logic                  pc_load;
        logic [15:0]           pc_value;
        logic [7:0]            vector;
        logic                  vector_valid;
    } pic_regs_t;

endpackage

/* File: hdl/pic_ctrl.sv */
// Prioritized interrupt controller with core entry and return sequencer
//
// Operation
// RL1: Interrupt activates on source event, mask update, or global enable rising.
// RL2: Entry starts only at a completed instruction boundary.
// RL3: Entry sequence lasts exactly 13 clock cycles until table reached.
// RL4: Entry pushes pc high byte, then pc low byte, then flags.
// RL5: Entry clears whole flag register, dropping global enable.
// RL6: Entry zeroes the pc high byte.
// RL7: Winning vector is delivered and loaded into pc low byte.
// RL8: Return pops flags, pc low, pc high and restores all three.
// RL9: Pending interrupts after return are taken before next instruction.
// RL10: Several pending requests yield the highest priority vector.
// RL11: Posted latch sets on event, holds until taken or cleared.
// RL12: Posted counts as pending only when masked in; taken only with global enable.
// RL13: Clearing a mask bit keeps posted requests and still lets new ones post.
// RL14: Software should clear posted requests before enabling a block.
// RL15: Fixed priorities; vector is four times priority, timer2 lowest.
// RL16: Reading the clear register shows posted requests.
// RL17: Soft post off: written zero clears, written one ignored.
// RL18: Soft post on: written zero ignored, written one posts.
// RL19: Clear register 0 bit order i2c, sleep, spi, gpio, timer0, cap, analog, vmon.
// RL20: Clear register works independently of the vector path.
// RL21: Software writes zero to reserved bits.
// RL22: Mask register 0 uses same bit order; bits act independently.
// RL23: Hardware posting wins over a software clear in the same cycle.
// RL24: Taking clears the winner's latch in the vector delivery cycle.
`timescale 1ns/1ps

module pic_ctrl
    import pic_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic      [7:0]           reg_rdata,
    input  wire logic [`PIC_NSRC-1:0] src_event,
    input  wire logic                 instr_done,
    input  wire logic                 return_from_irq,
    input  wire logic [15:0]          core_pc,
    input  wire logic [7:0]           pop_data,
    output logic                      core_hold,
    output logic                      stack_push,
    output logic      [7:0]           stack_push_data,
    output logic                      stack_pop,
    output logic                      pc_load,
    output logic      [15:0]          pc_value,
    output logic      [7:0]           irq_vector,
    output logic                      irq_vector_valid,
    output logic                      global_irq_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Priority encoder

    function automatic logic [7:0] pic_vec(input logic [`PIC_NSRC-1:0] req);
        logic [7:0] v;
        v = `PIC_RST_BYTE;
        for (int i = `PIC_NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                v = 8'((i + 1) * `PIC_VEC_STEP); // RL15
            end
        end
        return v;
    endfunction

    function automatic logic [`PIC_NSRC-1:0] pic_win(input logic [`PIC_NSRC-1:0] req);
        logic [`PIC_NSRC-1:0] w;
        w = '0;
        for (int i = `PIC_NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                w    = '0;
                w[i] = 1'b1; // RL10
            end
        end
        return w;
    endfunction

    // Clear and mask byte 0 swap i2c and sleep against priority order
    function automatic logic [7:0] pic_swap(input logic [7:0] b);
        return {b[6], b[7], b[5:0]}; // RL19 RL22
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    pic_regs_t r_q;
    pic_regs_t r_d;

    logic [`PIC_NSRC-1:0] pending;
    logic [`PIC_NSRC-1:0] sw_set;
    logic [`PIC_NSRC-1:0] sw_clr;
    logic [`PIC_NSRC-1:0] take_clr;
    logic [7:0]           flags_now;
    logic                 take;

    always_comb begin
        r_d      = r_q;
        sw_set   = '0;
        sw_clr   = '0;
        take_clr = '0;
        take     = 1'b0;
        pending  = r_q.posted & r_q.mask; // RL12 RL13 RL22

        // One-cycle strobes default low
        r_d.push         = 1'b0;
        r_d.pop          = 1'b0;
        r_d.pc_load      = 1'b0;
        r_d.vector_valid = 1'b0;
        r_d.rdata        = `PIC_RST_BYTE;

        ////////////////////////////////////////////////////////////////////////
        // Register writes

        if (reg_write) begin
            if (reg_addr == `PIC_ADDR_CLEAR0) begin
                if (r_q.swpost) begin
                    sw_set[7:0] = pic_swap(reg_wdata); // RL18 RL19
                end else begin
                    sw_clr[7:0] = ~pic_swap(reg_wdata); // RL17 RL19
                end
            end else if (reg_addr == `PIC_ADDR_CLEAR1) begin
                if (r_q.swpost) begin
                    sw_set[`PIC_NSRC-1:8] = reg_wdata[`PIC_CLEAR1_BITS-1:0]; // RL18
                end else begin
                    sw_clr[`PIC_NSRC-1:8] = ~reg_wdata[`PIC_CLEAR1_BITS-1:0]; // RL17
                end
            end else if (reg_addr == `PIC_ADDR_MASK0) begin
                r_d.mask[7:0] = pic_swap(reg_wdata); // RL1 RL22
            end else if (reg_addr == `PIC_ADDR_MASK1) begin
                r_d.mask[`PIC_NSRC-1:8] = reg_wdata[`PIC_CLEAR1_BITS-1:0];
            end else if (reg_addr == `PIC_ADDR_SWPOST) begin
                r_d.swpost = reg_wdata[`PIC_SWPOST_EN];
            end else if (reg_addr == `PIC_ADDR_FLAGS) begin
                r_d.flags = reg_wdata; // RL1
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Register reads

        if (reg_read) begin
            if (reg_addr == `PIC_ADDR_CLEAR0) begin
                r_d.rdata = pic_swap(r_q.posted[7:0]); // RL16 RL20
            end else if (reg_addr == `PIC_ADDR_CLEAR1) begin
                r_d.rdata = {6'h00, r_q.posted[`PIC_NSRC-1:8]}; // RL16
            end else if (reg_addr == `PIC_ADDR_MASK0) begin
                r_d.rdata = pic_swap(r_q.mask[7:0]);
            end else if (reg_addr == `PIC_ADDR_MASK1) begin
                r_d.rdata = {6'h00, r_q.mask[`PIC_NSRC-1:8]};
            end else if (reg_addr == `PIC_ADDR_SWPOST) begin
                r_d.rdata = {7'h00, r_q.swpost};
            end else if (reg_addr == `PIC_ADDR_FLAGS) begin
                r_d.rdata = r_q.flags;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Entry and return sequencer

        flags_now = r_q.flags;

        case (r_q.state)
            PIC_IDLE: begin
                r_d.busy = 1'b0;
                if (instr_done && return_from_irq) begin
                    r_d.state = PIC_RET;
                    r_d.cnt   = 4'h0;
                    r_d.busy  = 1'b1;
                end else if (instr_done && (|pending) && flags_now[`PIC_FLAG_GIE]) begin
                    take        = 1'b1; // RL2 RL12
                    r_d.pc_save = core_pc;
                end
            end
            PIC_ENTRY: begin
                r_d.cnt = r_q.cnt + 4'h1;
                if (r_q.cnt < `PIC_PUSH_CYCLES) begin
                    r_d.push = 1'b1; // RL4
                    if (r_q.cnt == 4'h0) begin
                        r_d.push_data = r_q.pc_save[15:8];
                    end else if (r_q.cnt == 4'h1) begin
                        r_d.push_data = r_q.pc_save[7:0];
                    end else begin
                        r_d.push_data = r_q.flags;
                    end
                end
                if (r_q.cnt == `PIC_PUSH_CYCLES) begin
                    r_d.flags = `PIC_RST_BYTE; // RL5
                end
                if (r_q.cnt == `PIC_ENTRY_CYCLES - 4'h2) begin
                    r_d.pc_load  = 1'b1; // RL3
                    r_d.pc_value = {8'h00, r_q.vector}; // RL6 RL7
                end
                if (r_q.cnt == `PIC_ENTRY_CYCLES - 4'h1) begin
                    r_d.state = PIC_IDLE; // RL3
                    r_d.busy  = 1'b0;
                end
            end
            PIC_RET: begin
                r_d.cnt = r_q.cnt + 4'h1;
                r_d.pop = (r_q.cnt <= 4'h2); // RL8
                if (r_q.cnt == 4'h2) begin
                    r_d.flags_tmp = pop_data; // RL8
                end
                if (r_q.cnt == 4'h3) begin
                    r_d.pc_save[7:0] = pop_data; // RL8
                end
                if (r_q.cnt == `PIC_RET_LAST) begin
                    r_d.flags    = r_q.flags_tmp; // RL8
                    r_d.pc_save  = {pop_data, r_q.pc_save[7:0]};
                    r_d.pc_load  = 1'b1;
                    r_d.pc_value = {pop_data, r_q.pc_save[7:0]};
                    r_d.state    = PIC_IDLE;
                    r_d.busy     = 1'b0;
                    if ((|pending) && r_q.flags_tmp[`PIC_FLAG_GIE]) begin
                        take = 1'b1; // RL9
                    end
                end
            end
            default: begin
                r_d.state = PIC_IDLE;
            end
        endcase

        if (take) begin
            take_clr         = pic_win(pending); // RL10 RL24
            r_d.vector       = pic_vec(pending); // RL7 RL10
            r_d.vector_valid = 1'b1;
            r_d.state        = PIC_ENTRY;
            r_d.cnt          = 4'h0;
            r_d.busy         = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////
        // Posted latches; posting beats clearing

        r_d.posted = (r_q.posted & ~(sw_clr | take_clr)) | src_event | sw_set; // RL11 RL23
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata         = r_q.rdata;
    assign core_hold         = r_q.busy;
    assign stack_push        = r_q.push;
    assign stack_push_data   = r_q.push_data;
    assign stack_pop         = r_q.pop;
    assign pc_load           = r_q.pc_load;
    assign pc_value          = r_q.pc_value;
    assign irq_vector        = r_q.vector;
    assign irq_vector_valid  = r_q.vector_valid;
    assign global_irq_enable = r_q.flags[`PIC_FLAG_GIE];

endmodule

/* File: tb/pic_core_model.sv */
// Core model: instruction boundaries, stack and program counter
`timescale 1ns/1ps
module pic_core_model
    import pic_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        step,
    input  wire logic        ret_step,
    input  wire logic        core_hold,
    input  wire logic        stack_push,
    input  wire logic [7:0]  stack_push_data,
    input  wire logic        stack_pop,
    input  wire logic        pc_load,
    input  wire logic [15:0] pc_value,
    output logic             instr_done,
    output logic             return_from_irq,
    output logic      [15:0] core_pc,
    output logic      [7:0]  pop_data
);
    logic [7:0] stk [0:15];
    logic [3:0] sp;
    always_ff @(posedge clock) begin
        if (reset) begin
            instr_done <= 1'h0;
            return_from_irq <= 1'h0;
            core_pc <= 16'h1234;
            pop_data <= 8'h00;
            sp <= 4'h0;
        end else begin
            instr_done <= step && !core_hold && !instr_done;
            return_from_irq <= ret_step;
            core_pc <= pc_load ? pc_value : core_pc + {15'h0, instr_done};
            pop_data <= stack_pop ? stk[sp - 4'h1] : ~pop_data;
            if (stack_push) begin
                stk[sp] <= stack_push_data;
                sp <= sp + 4'h1;
            end else if (stack_pop) begin
                sp <= sp - 4'h1;
            end
        end
    end
endmodule

/* File: tb/pic_ctrl_monitor.sv */
// Port assertions for the interrupt controller
`timescale 1ns/1ps
module pic_ctrl_monitor
    import pic_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        instr_done,
    input wire logic        return_from_irq,
    input wire logic [15:0] core_pc,
    input wire logic [7:0]  pop_data,
    input wire logic        core_hold,
    input wire logic        stack_push,
    input wire logic [7:0]  stack_push_data,
    input wire logic        stack_pop,
    input wire logic        pc_load,
    input wire logic [15:0] pc_value,
    input wire logic [7:0]  irq_vector,
    input wire logic        irq_vector_valid,
    input wire logic        global_irq_enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_ret_go;
        instr_done && return_from_irq && !core_hold;
    endsequence
    sequence s_pops;
        stack_pop [*3];
    endsequence
    property p_len;
        irq_vector_valid |-> ##12 (pc_load && core_hold);
    endproperty
    a_len: assert property (p_len) else $error("entry length");
    property p_push;
        irq_vector_valid && $past(instr_done) |->
            ##1 (stack_push && stack_push_data == $past(core_pc[15:8], 2))
            ##1 (stack_push && stack_push_data == $past(core_pc[7:0], 3)) ##1 stack_push;
    endproperty
    a_push: assert property (p_push) else $error("push order");
    property p_gie;
        irq_vector_valid |-> ##4 !global_irq_enable;
    endproperty
    a_gie: assert property (p_gie) else $error("flags not cleared");
    property p_pc;
        irq_vector_valid |-> ##12 pc_value == {8'h00, irq_vector};
    endproperty
    a_pc: assert property (p_pc) else $error("entry pc");
    property p_code;
        irq_vector_valid |-> irq_vector[1:0] == 2'h0 && irq_vector >= 8'h04 && irq_vector <= 8'h28;
    endproperty
    a_code: assert property (p_code) else $error("vector code");
    property p_take;
        irq_vector_valid |-> global_irq_enable;
    endproperty
    a_take: assert property (p_take) else $error("taken while disabled");
    property p_bound;
        $rose(core_hold) |-> $past(instr_done);
    endproperty
    a_bound: assert property (p_bound) else $error("start off boundary");
    property p_ret;
        s_ret_go |-> ##2 s_pops ##2 (pc_load && pc_value == {$past(pop_data), $past(pop_data, 2)}
            && global_irq_enable == $past(pop_data[0], 3));
    endproperty
    a_ret: assert property (p_ret) else $error("return restore");
endmodule
bind pic_ctrl pic_ctrl_monitor pic_ctrl_monitor_i (.clock, .reset, .instr_done, .return_from_irq,
    .core_pc, .pop_data, .core_hold, .stack_push, .stack_push_data, .stack_pop, .pc_load,
    .pc_value, .irq_vector, .irq_vector_valid, .global_irq_enable);

/* File: tb/pic_ctrl_tb.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "pic_defines.svh"
module pic_ctrl_tb
    import pic_pkg::*;
;
    logic clock = 1'h0, reset = 1'h1, reg_write = 1'h0, reg_read = 1'h0, step = 1'h0;
    logic ret_step = 1'h0, instr_done, return_from_irq, core_hold, stack_push, stack_pop;
    logic pc_load, irq_vector_valid, global_irq_enable;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, stack_push_data, pop_data;
    logic [7:0] irq_vector;
    logic [`PIC_NSRC-1:0] src_event = 10'h000;
    logic [15:0] core_pc, pc_value, saved;
    int n_errors = 0, n_checks = 0;
    always #2 clock = ~clock;
    pic_ctrl pic_ctrl_i (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .src_event, .instr_done, .return_from_irq, .core_pc, .pop_data, .core_hold,
        .stack_push, .stack_push_data, .stack_pop, .pc_load, .pc_value, .irq_vector,
        .irq_vector_valid, .global_irq_enable);
    pic_core_model pic_core_model_i (.clock, .reset, .step, .ret_step, .core_hold, .stack_push,
        .stack_push_data, .stack_pop, .pc_load, .pc_value, .instr_done, .return_from_irq,
        .core_pc, .pop_data);
    task automatic end_sim;
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= w;
        reg_read <= !w;
        @(posedge clock);
        reg_write <= 1'h0;
        reg_read <= 1'h0;
        #1;
        if (!w) chk(reg_rdata, d);
    endtask
    task automatic post(input logic [9:0] s);
        @(posedge clock);
        src_event <= s;
        @(posedge clock);
        src_event <= 10'h000;
    endtask
    task automatic instr(input logic r);
        @(posedge clock);
        step <= 1'h1;
        ret_step <= r;
        @(posedge clock);
        step <= 1'h0;
        ret_step <= 1'h0;
    endtask
    task automatic take(input logic [7:0] v);
        int i, j;
        #1;
        for (i = 0; i < 60 && irq_vector_valid !== 1'h1; i++) #4;
        chk(irq_vector, v);
        for (j = 0; j < 60 && core_hold !== 1'h0; j++) #4;
        if (i == 60 || j == 60) begin
            n_errors++;
            $display("Error at %0t: timeout", $time);
            end_sim;
        end
        chk(core_pc, {8'h00, v});
        chk(global_irq_enable, 1'h0);
    endtask
    task automatic none;
        int k = 0;
        repeat (30) begin
            @(posedge clock);
            #1;
            k += int'(irq_vector_valid === 1'h1);
        end
        chk(16'(k), 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'h0;
        bus(8'hDA, 8'h00, 1'h0);
        bus(8'hE0, 8'h00, 1'h0);
        bus(8'h77, 8'h00, 1'h0);
        $display("reset test done");
        post(10'h3FF);
        bus(8'hDA, 8'hFF, 1'h0);
        bus(8'hDB, 8'h03, 1'h0);
        bus(8'hDA, 8'hFF, 1'h1);
        bus(8'hDA, 8'hFF, 1'h0);
        bus(8'hDA, 8'h0F, 1'h1);
        bus(8'hDA, 8'h0F, 1'h0);
        @(posedge clock);
        src_event <= 10'h001;
        reg_addr <= 8'hDA;
        reg_wdata <= 8'h00;
        reg_write <= 1'h1;
        @(posedge clock);
        src_event <= 10'h000;
        reg_write <= 1'h0;
        bus(8'hDA, 8'h01, 1'h0);
        bus(8'hE2, 8'h01, 1'h1);
        bus(8'hDA, 8'hA4, 1'h1);
        bus(8'hDA, 8'h00, 1'h1);
        bus(8'hDA, 8'hA5, 1'h0);
        bus(8'hE2, 8'h00, 1'h1);
        bus(8'hDA, 8'h00, 1'h1);
        bus(8'hDB, 8'h00, 1'h1);
        bus(8'hDB, 8'h00, 1'h0);
        bus(8'hDA, 8'h00, 1'h0);
        $display("clear test done");
        bus(8'hF0, 8'h01, 1'h1);
        post(10'h010);
        instr(1'h0);
        none();
        bus(8'hDA, 8'h10, 1'h0);
        bus(8'hE0, 8'h10, 1'h1);
        instr(1'h0);
        take(8'h14);
        bus(8'hDA, 8'h00, 1'h0);
        $display("mask test done");
        bus(8'hE0, 8'hFF, 1'h1);
        bus(8'hE1, 8'h03, 1'h1);
        post(10'h228);
        bus(8'hF0, 8'h01, 1'h1);
        saved = core_pc;
        instr(1'h0);
        take(8'h10);
        instr(1'h1);
        take(8'h18);
        instr(1'h1);
        take(8'h28);
        instr(1'h1);
        none();
        chk(core_pc, saved);
        chk(global_irq_enable, 1'h1);
        $display("priority test done");
        end_sim;
    end
endmodule
